// ### keypad_image_pkg.sv
// Purpose: shared constants and types for the keypad process image block
// Assumes: apb slave with 32-bit data, one register per aligned word
// Notes: area offsets are register indices, byte address is base plus four times index
package keypad_image_pkg;

    // ----------------------------------------------------------------
    // image geometry
    // ----------------------------------------------------------------
    localparam int BYTE_W = 8;
    localparam int LED_COUNT = 8;
    localparam int DATA_W = 32;

    // ----------------------------------------------------------------
    // register indices within each area
    // ----------------------------------------------------------------
    localparam int IDX_KEY_STATE = 'h0;
    localparam int IDX_INPUT_LEVEL = 'h1;
    localparam int IDX_RED_LED = 'h0;
    localparam int IDX_GREEN_LED = 'h1;
    localparam int IDX_BLUE_LED = 'h2;
    localparam int IDX_OUTPUT_LEVEL = 'h3;

    // ----------------------------------------------------------------
    // area bases and byte addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] IN_AREA_BASE = 8'h00;
    localparam logic [7:0] OUT_AREA_BASE = 8'h10;
    localparam logic [7:0] COLOUR_STATE_ADDR = 8'h20;
    localparam logic [7:0] KEY_STATE_ADDR = 8'(IN_AREA_BASE + 4 * IDX_KEY_STATE);
    localparam logic [7:0] INPUT_LEVEL_ADDR = 8'(IN_AREA_BASE + 4 * IDX_INPUT_LEVEL);
    localparam logic [7:0] RED_LED_ADDR = 8'(OUT_AREA_BASE + 4 * IDX_RED_LED);
    localparam logic [7:0] GREEN_LED_ADDR = 8'(OUT_AREA_BASE + 4 * IDX_GREEN_LED);
    localparam logic [7:0] BLUE_LED_ADDR = 8'(OUT_AREA_BASE + 4 * IDX_BLUE_LED);
    localparam logic [7:0] OUTPUT_LEVEL_ADDR = 8'(OUT_AREA_BASE + 4 * IDX_OUTPUT_LEVEL);

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] OUT_BYTE_RESET = 8'h00;
    localparam logic [7:0] IN_BYTE_RESET = 8'h00;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

    // ----------------------------------------------------------------
    // colour field of the readback register, three bits per led
    // ----------------------------------------------------------------
    localparam int COLOUR_FIELD_W = 3;

    typedef enum logic [2:0] {
        lamp_off,
        lamp_red,
        lamp_green,
        lamp_blue,
        lamp_yellow,
        lamp_white
    } lamp_colour_t;

endpackage : keypad_image_pkg

// ### lamp_colour_decode.sv
// Purpose: decode one led's colour bits into a lamp colour and its drives
// Assumes: purely combinational, registered by the caller
// Notes: mixed blue combinations other than white are forced dark
`timescale 1ns/100ps
`default_nettype none
module lamp_colour_decode
    import keypad_image_pkg::*;
(
    input wire logic red_bit,
    input wire logic green_bit,
    input wire logic blue_bit,
    output lamp_colour_t colour,
    output logic red_drive,
    output logic green_drive,
    output logic blue_drive
);

    // ----------------------------------------------------------------
    // colour table
    // ----------------------------------------------------------------
    always_comb begin
        unique case ({red_bit, green_bit, blue_bit})
            3'b100: colour = lamp_red;
            3'b010: colour = lamp_green;
            3'b001: colour = lamp_blue;
            3'b110: colour = lamp_yellow;
            3'b111: colour = lamp_white;
            3'b000, 3'b101, 3'b011: colour = lamp_off;
        endcase
    end

    // off wins: a dark colour drives no element at all
    assign red_drive = (colour != lamp_off) && red_bit;
    assign green_drive = (colour != lamp_off) && green_bit;
    assign blue_drive = (colour != lamp_off) && blue_bit;

endmodule : lamp_colour_decode
`default_nettype wire

// ### process_image_inputs.sv
// Purpose: capture key states and input levels into the standard input image
// Assumes: inputs synchronous to pclk
// Notes: fail-safe channels never reach this image
`timescale 1ns/100ps
`default_nettype none
module process_image_inputs
    import keypad_image_pkg::*;
#(
    parameter int WIDTH = LED_COUNT
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] pushbutton_state,
    input wire logic [WIDTH-1:0] switch_input_level,
    output logic [WIDTH-1:0] key_image,
    output logic [WIDTH-1:0] level_image
);

    typedef struct packed {
        logic [WIDTH-1:0] keys;
        logic [WIDTH-1:0] levels;
    } in_state_t;

    in_state_t state_q;
    in_state_t state_d;

    // elaboration refuses widths that do not fit one image byte
    if (WIDTH < 1 || WIDTH > BYTE_W) begin : g_bad_width
        $error("image width must be 1 to 8");
    end

    // ----------------------------------------------------------------
    // image capture
    // ----------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        state_d.keys = pushbutton_state;
        state_d.levels = switch_input_level;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign key_image = state_q.keys;
    assign level_image = state_q.levels;

    // the release edge itself still resets, so only edges seen out of reset are checked
    a_image_follows_keys: assert property (@(posedge pclk) disable iff (!presetn)
        presetn |=> key_image == $past(pushbutton_state) && level_image == $past(switch_input_level))
        else $error("input image does not follow its own pins");

endmodule : process_image_inputs
`default_nettype wire

// ### keypad_led_process_image.sv
// Purpose: apb view of the standard-mode process image of an operator keypad
// Assumes: apb with zero wait states, pclk 125 MHz, inputs synchronous to pclk
// Notes: led drives follow the written colour bytes one cycle later
`timescale 1ns/100ps
`default_nettype none
module keypad_led_process_image
    import keypad_image_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int LEDS = LED_COUNT
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [LEDS-1:0] pushbutton_state,
    input wire logic [LEDS-1:0] switch_input_level,
    output logic [LEDS-1:0] led_red_drive,
    output logic [LEDS-1:0] led_green_drive,
    output logic [LEDS-1:0] led_blue_drive,
    output logic [LEDS-1:0] switched_output_level
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [LEDS-1:0] red;
        logic [LEDS-1:0] green;
        logic [LEDS-1:0] blue;
        logic [LEDS-1:0] dout;
        logic [LEDS-1:0] drv_red;
        logic [LEDS-1:0] drv_green;
        logic [LEDS-1:0] drv_blue;
        logic [DATA_W-1:0] rdata;
        logic err;
    } out_state_t;

    out_state_t state_q;
    out_state_t state_d;

    logic [LEDS-1:0] key_image;
    logic [LEDS-1:0] level_image;
    logic [LEDS-1:0] dec_red;
    logic [LEDS-1:0] dec_green;
    logic [LEDS-1:0] dec_blue;
    logic [LEDS*COLOUR_FIELD_W-1:0] colour_word;
    logic setup_phase;
    logic write_take;
    logic mapped;
    logic writable;

    // elaboration refuses sizes the map and the byte lanes cannot hold
    if (ADDR_W < 6 || ADDR_W > 32) begin : g_bad_addr_w
        $error("address width must be 6 to 32");
    end
    if (LEDS < 1 || LEDS > BYTE_W) begin : g_bad_leds
        $error("led count must be 1 to 8");
    end

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] byte_addr);
        return a == ADDR_W'(byte_addr);
    endfunction : hit

    assign setup_phase = psel && !penable;
    assign pready = psel && penable;
    assign write_take = pready && pwrite;
    assign writable = hit(paddr, RED_LED_ADDR) || hit(paddr, GREEN_LED_ADDR)
        || hit(paddr, BLUE_LED_ADDR) || hit(paddr, OUTPUT_LEVEL_ADDR);
    assign mapped = writable || hit(paddr, KEY_STATE_ADDR) || hit(paddr, INPUT_LEVEL_ADDR)
        || hit(paddr, COLOUR_STATE_ADDR);

    // ----------------------------------------------------------------
    // input image
    // ----------------------------------------------------------------
    process_image_inputs #(
        .WIDTH(LEDS)
    ) u_inputs (
        .pclk(pclk),
        .presetn(presetn),
        .pushbutton_state(pushbutton_state),
        .switch_input_level(switch_input_level),
        .key_image(key_image),
        .level_image(level_image)
    );

    // ----------------------------------------------------------------
    // per-led colour decode
    // ----------------------------------------------------------------
    for (genvar i = 0; i < LEDS; i++) begin : g_led
        lamp_colour_decode u_decode (
            .red_bit(state_q.red[i]),
            .green_bit(state_q.green[i]),
            .blue_bit(state_q.blue[i]),
            .colour(colour_word[i*COLOUR_FIELD_W +: COLOUR_FIELD_W]),
            .red_drive(dec_red[i]),
            .green_drive(dec_green[i]),
            .blue_drive(dec_blue[i])
        );
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        // registered drives keep glitches of the decode off the lamp pins
        state_d.drv_red = dec_red;
        state_d.drv_green = dec_green;
        state_d.drv_blue = dec_blue;
        // read data is caught in setup so that access answers at once
        if (setup_phase) begin
            state_d.rdata = RDATA_RESET;
            state_d.err = !mapped || (pwrite && !writable);
            if (!pwrite) begin
                if (hit(paddr, KEY_STATE_ADDR)) begin
                    state_d.rdata[LEDS-1:0] = key_image;
                end
                if (hit(paddr, INPUT_LEVEL_ADDR)) begin
                    state_d.rdata[LEDS-1:0] = level_image;
                end
                if (hit(paddr, RED_LED_ADDR)) begin
                    state_d.rdata[LEDS-1:0] = state_q.red;
                end
                if (hit(paddr, GREEN_LED_ADDR)) begin
                    state_d.rdata[LEDS-1:0] = state_q.green;
                end
                if (hit(paddr, BLUE_LED_ADDR)) begin
                    state_d.rdata[LEDS-1:0] = state_q.blue;
                end
                if (hit(paddr, OUTPUT_LEVEL_ADDR)) begin
                    state_d.rdata[LEDS-1:0] = state_q.dout;
                end
                if (hit(paddr, COLOUR_STATE_ADDR)) begin
                    state_d.rdata[LEDS*COLOUR_FIELD_W-1:0] = colour_word;
                end
            end
        end
        // a write lands only at the access edge and only in lane 0
        if (write_take && pstrb[0]) begin
            if (hit(paddr, RED_LED_ADDR)) begin
                state_d.red = pwdata[LEDS-1:0];
            end
            if (hit(paddr, GREEN_LED_ADDR)) begin
                state_d.green = pwdata[LEDS-1:0];
            end
            if (hit(paddr, BLUE_LED_ADDR)) begin
                state_d.blue = pwdata[LEDS-1:0];
            end
            if (hit(paddr, OUTPUT_LEVEL_ADDR)) begin
                state_d.dout = pwdata[LEDS-1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q.red <= OUT_BYTE_RESET[LEDS-1:0];
            state_q.green <= OUT_BYTE_RESET[LEDS-1:0];
            state_q.blue <= OUT_BYTE_RESET[LEDS-1:0];
            state_q.dout <= OUT_BYTE_RESET[LEDS-1:0];
            state_q.drv_red <= '0;
            state_q.drv_green <= '0;
            state_q.drv_blue <= '0;
            state_q.rdata <= RDATA_RESET;
            state_q.err <= 1'b0;
        end else begin
            state_q <= state_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign prdata = state_q.rdata;
    assign pslverr = pready && state_q.err;
    assign led_red_drive = state_q.drv_red;
    assign led_green_drive = state_q.drv_green;
    assign led_blue_drive = state_q.drv_blue;
    assign switched_output_level = state_q.dout;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic written_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            written_q <= 1'b0;
        end else if (write_take && writable) begin
            written_q <= 1'b1;
        end
    end

    a_key_byte_read: assert property (@(posedge pclk) disable iff (!presetn)
        setup_phase && !pwrite && hit(paddr, KEY_STATE_ADDR)
        |=> prdata[LEDS-1:0] == $past(key_image) && pready)
        else $error("key byte read does not show the key image");

    a_level_byte_read: assert property (@(posedge pclk) disable iff (!presetn)
        setup_phase && !pwrite && hit(paddr, INPUT_LEVEL_ADDR)
        |=> prdata[LEDS-1:0] == $past(level_image) && !pslverr)
        else $error("level byte read does not show the input levels");

    // colour readback is caught in setup like every other read
    a_colour_state_read: assert property (@(posedge pclk) disable iff (!presetn)
        setup_phase && !pwrite && hit(paddr, COLOUR_STATE_ADDR)
        |=> prdata[LEDS*COLOUR_FIELD_W-1:0] == $past(colour_word))
        else $error("colour state read does not show the decoded colours");

    a_red_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
        write_take && pstrb[0] && hit(paddr, RED_LED_ADDR)
        |=> state_q.red == $past(pwdata[LEDS-1:0]))
        else $error("red byte write did not land");

    a_green_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
        write_take && pstrb[0] && hit(paddr, GREEN_LED_ADDR)
        |=> state_q.green == $past(pwdata[LEDS-1:0]))
        else $error("green byte write did not land");

    a_blue_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
        write_take && pstrb[0] && hit(paddr, BLUE_LED_ADDR)
        |=> state_q.blue == $past(pwdata[LEDS-1:0]))
        else $error("blue byte write did not land");

    a_dout_write_pins: assert property (@(posedge pclk) disable iff (!presetn)
        write_take && pstrb[0] && hit(paddr, OUTPUT_LEVEL_ADDR)
        |=> switched_output_level == $past(pwdata[LEDS-1:0]))
        else $error("digital output pins do not follow byte 3");

    a_white_all_on: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q.red & state_q.green & state_q.blue) != '0
        |=> (led_red_drive & led_green_drive & led_blue_drive) == $past(state_q.red & state_q.green & state_q.blue))
        else $error("white combination not driving all three elements");

    // per-led checks: a fault in one decoder slice must not hide behind led 0
    for (genvar j = 0; j < LEDS; j++) begin : g_led_check
        a_red_only_red: assert property (@(posedge pclk) disable iff (!presetn)
            state_q.red[j] && !state_q.green[j] && !state_q.blue[j]
            |=> led_red_drive[j] && !led_green_drive[j] && !led_blue_drive[j])
            else $error("red combination not shown as red");

        a_yellow_two_on: assert property (@(posedge pclk) disable iff (!presetn)
            state_q.red[j] && state_q.green[j] && !state_q.blue[j]
            |=> led_red_drive[j] && led_green_drive[j] && !led_blue_drive[j])
            else $error("yellow combination not driving red and green");

        a_mixed_blue_off: assert property (@(posedge pclk) disable iff (!presetn)
            (state_q.blue[j] && (state_q.red[j] ^ state_q.green[j]))
            |=> !led_red_drive[j] && !led_green_drive[j] && !led_blue_drive[j])
            else $error("forbidden colour combination lit a led");
    end

    a_reset_dark: assert property (@(posedge pclk) disable iff (!presetn)
        !written_q |-> led_red_drive == '0 && led_green_drive == '0
        && led_blue_drive == '0 && switched_output_level == '0)
        else $error("outputs not dark before the first write");

    a_ro_write_refused: assert property (@(posedge pclk) disable iff (!presetn)
        write_take && hit(paddr, KEY_STATE_ADDR)
        |-> pslverr ##1 $stable(state_q.red) && $stable(state_q.dout))
        else $error("write to input image not refused");

    c_colour_write: cover property (@(posedge pclk) disable iff (!presetn)
        write_take && hit(paddr, GREEN_LED_ADDR) ##2 led_green_drive != '0);

    c_key_read: cover property (@(posedge pclk) disable iff (!presetn)
        pready && !pwrite && hit(paddr, KEY_STATE_ADDR) && prdata != '0);

    c_yellow_lamp: cover property (@(posedge pclk) disable iff (!presetn)
        (led_red_drive & led_green_drive & ~led_blue_drive) != '0);

    c_white_lamp: cover property (@(posedge pclk) disable iff (!presetn)
        (led_red_drive & led_green_drive & led_blue_drive) != '0);

    c_unmapped_err: cover property (@(posedge pclk) disable iff (!presetn)
        pready && pslverr && !mapped);

endmodule : keypad_led_process_image
`default_nettype wire

// ### controller_model.sv
// Purpose: apb master standing in for the remote controller
// Assumes: slave answers with pready; the wait for it is bounded
// Notes: one colour component or output byte goes out per word
`timescale 1ns/100ps
`default_nettype none
module controller_model
    import keypad_image_pkg::*;
(
    input wire logic pclk,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [DATA_W-1:0] prdata,
    output var logic psel,
    output var logic penable,
    output var logic pwrite,
    output var logic [7:0] paddr,
    output var logic [DATA_W-1:0] pwdata,
    output var logic [3:0] pstrb
);
    // ----------------------------------------------------------------
    // idle bus
    // ----------------------------------------------------------------
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
    end

    // ----------------------------------------------------------------
    // one transfer; colour bytes are written one per word
    // ----------------------------------------------------------------
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                        input logic [3:0] strb, output logic [31:0] rdata, output logic err,
                        output logic ok);
        ok = 1'b0;
        err = 1'b0;
        rdata = 32'h0000_0000;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        pstrb <= strb;
        @(posedge pclk);
        penable <= 1'b1;
        for (int n = 0; n < 16 && !ok; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) begin
                ok = 1'b1;
                rdata = prdata;
                err = pslverr;
            end
        end
        psel <= 1'b0;
        penable <= 1'b0;
        // stale data would hide a slave that samples too late
        pwdata <= ~wdata;
    endtask : xfer
endmodule : controller_model
`default_nettype wire

// ### testbench.sv
// Purpose: self-checking bench for the keypad process image block
// Assumes: zero wait state apb slave, outputs registered
// Notes: led drives checked a fixed three edges after the last write
`timescale 1ns/100ps
`default_nettype none
module testbench
    import keypad_image_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr, keys, levels, drv_r, drv_g, drv_b, outs, k;
    logic [3:0] pstrb;
    logic [31:0] pwdata, prdata, ec;
    logic [2:0] code;
    int num_errors = 0;
    int n_checks = 0;

    keypad_led_process_image i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pushbutton_state(keys), .switch_input_level(levels),
        .led_red_drive(drv_r), .led_green_drive(drv_g), .led_blue_drive(drv_b),
        .switched_output_level(outs));
    controller_model i_ctrl (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));

    initial pclk = 1'b0;
    always #4 pclk = ~pclk;

    // ----------------------------------------------------------------
    // checking and bus tasks
    // ----------------------------------------------------------------
    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic access(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                          input logic [3:0] strb, input logic [31:0] exp, input logic exp_err);
        logic [31:0] d;
        logic e, ok;
        i_ctrl.xfer(wr, addr, wdata, strb, d, e, ok);
        if (ok !== 1'b1) begin
            num_errors++;
            $display("wrong value pready expected 1 seen 0 at %h", addr);
            print_verdict();
        end
        if (!wr) check("read data", d, exp);
        check("slave error", 32'(e), 32'(exp_err));
    endtask : access

    task automatic drives(input logic [7:0] r, input logic [7:0] g, input logic [7:0] b, input logic [7:0] o);
        #1;
        check("red drive", 32'(drv_r), 32'(r));
        check("green drive", 32'(drv_g), 32'(g));
        check("blue drive", 32'(drv_b), 32'(b));
        check("output level", 32'(outs), 32'(o));
    endtask : drives

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        keys = 8'h00;
        levels = 8'h00;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        drives(8'h00, 8'h00, 8'h00, 8'h00);
        access(1'b0, RED_LED_ADDR, 32'h0, 4'h0, 32'h0, 1'b0);
        access(1'b0, OUTPUT_LEVEL_ADDR, 32'h0, 4'h0, 32'h0, 1'b0);
        // walking one on keys, walking zero on inputs, so swapped bytes show up
        for (int n = 0; n < 8; n++) begin
            @(posedge pclk);
            keys <= 8'h01 << n;
            levels <= ~(8'h01 << n);
            repeat (2) @(posedge pclk);
            access(1'b0, KEY_STATE_ADDR, 32'h0, 4'h0, 32'(8'h01 << n), 1'b0);
            access(1'b0, INPUT_LEVEL_ADDR, 32'h0, 4'h0, {24'h0, ~(8'h01 << n)}, 1'b0);
        end
        // every led gets its own rgb code; second pass inverts all codes
        for (int p = 0; p < 2; p++) begin
            k = (p == 1) ? 8'hff : 8'h00;
            access(1'b1, RED_LED_ADDR, 32'(8'hf0 ^ k), 4'h1, 32'h0, 1'b0);
            access(1'b1, GREEN_LED_ADDR, 32'(8'hcc ^ k), 4'h1, 32'h0, 1'b0);
            access(1'b1, BLUE_LED_ADDR, 32'(8'haa ^ k), 4'h1, 32'h0, 1'b0);
            ec = 32'h0;
            for (int i = 0; i < 8; i++) begin
                code = 3'(i) ^ k[2:0];
                case (code)
                    3'h4: ec[3*i +: 3] = lamp_red;
                    3'h2: ec[3*i +: 3] = lamp_green;
                    3'h1: ec[3*i +: 3] = lamp_blue;
                    3'h6: ec[3*i +: 3] = lamp_yellow;
                    3'h7: ec[3*i +: 3] = lamp_white;
                    default: ec[3*i +: 3] = lamp_off;
                endcase
            end
            repeat (3) @(posedge pclk);
            if (p == 0) drives(8'hd0, 8'hc4, 8'h82, 8'h00);
            else drives(8'h0b, 8'h23, 8'h41, 8'h00);
            access(1'b0, COLOUR_STATE_ADDR, 32'h0, 4'h0, ec, 1'b0);
        end
        access(1'b1, OUTPUT_LEVEL_ADDR, 32'h0000_00a5, 4'h1, 32'h0, 1'b0);
        repeat (3) @(posedge pclk);
        drives(8'h0b, 8'h23, 8'h41, 8'ha5);
        access(1'b0, OUTPUT_LEVEL_ADDR, 32'h0, 4'h0, 32'h0000_00a5, 1'b0);
        // key activity must not leak into the output image
        keys <= 8'h3c;
        levels <= 8'hc3;
        repeat (3) @(posedge pclk);
        drives(8'h0b, 8'h23, 8'h41, 8'ha5);
        // refusals: read-only, unmapped, disabled lane
        access(1'b1, KEY_STATE_ADDR, 32'h0000_00ff, 4'h1, 32'h0, 1'b1);
        access(1'b0, KEY_STATE_ADDR, 32'h0, 4'h0, 32'h0000_003c, 1'b0);
        access(1'b0, 8'h30, 32'h0, 4'h0, 32'h0, 1'b1);
        access(1'b1, RED_LED_ADDR, 32'h0000_00ff, 4'h0, 32'h0, 1'b0);
        access(1'b0, RED_LED_ADDR, 32'h0, 4'h0, 32'h0000_000f, 1'b0);
        // reset in mid-run clears every drive
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        drives(8'h00, 8'h00, 8'h00, 8'h00);
        @(posedge pclk);
        presetn <= 1'b1;
        access(1'b0, BLUE_LED_ADDR, 32'h0, 4'h0, 32'h0, 1'b0);
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
